// *** hw/sari_device.sv ***
// Converter end: frame sequencing, track/hold, result shifting and power mode control.
`include "sari_defs.svh"
`default_nettype none
module sari_device #(
	parameter int unsigned RESULT_BITS = `SARI_RESULT_BITS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	sari_link_if.device link,
	input wire logic [RESULT_BITS-1:0] sample_in,
	output logic in_hold,
	output logic in_shutdown,
	output logic frame_active
);
	// One extra zero sits on the line from select falling until the first
	// falling clock edge; a host that idles its clock high never captures it.
	localparam int FRAME_W = `SARI_LEAD_ZEROS + 1 + RESULT_BITS + `SARI_TRAIL_ZEROS;

	// Both pins come from the host's side, so each passes three flops and a
	// change is accepted only once the last two stages agree.
	logic [2:0] cs_sync_q;
	logic [2:0] sclk_sync_q;
	logic cs_lvl_q;
	logic sclk_lvl_q;
	logic cs_lvl_d;
	logic sclk_lvl_d;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cs_sync_q <= 3'h7;
			sclk_sync_q <= 3'h7;
		end else if (clk_en) begin
			cs_sync_q <= {cs_sync_q[1:0], link.cs_n};
			sclk_sync_q <= {sclk_sync_q[1:0], link.sclk};
		end
	end

	assign cs_lvl_d = (cs_sync_q[1] == cs_sync_q[2]) ? cs_sync_q[2] : cs_lvl_q;
	assign sclk_lvl_d = (sclk_sync_q[1] == sclk_sync_q[2]) ? sclk_sync_q[2] : sclk_lvl_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cs_lvl_q <= 1'b1;
			sclk_lvl_q <= 1'b1;
		end else if (clk_en) begin
			cs_lvl_q <= cs_lvl_d;
			sclk_lvl_q <= sclk_lvl_d;
		end
	end

	wire cs_fall = cs_lvl_q & ~cs_lvl_d;
	wire cs_rise = ~cs_lvl_q & cs_lvl_d;
	wire sclk_fall = sclk_lvl_q & ~sclk_lvl_d;
	wire sclk_rise = ~sclk_lvl_q & sclk_lvl_d;

	// Frame state and edge counters.
	logic active_q;
	logic [`SARI_CNT_W-1:0] fall_cnt_q;
	logic [`SARI_CNT_W-1:0] rise_cnt_q;
	logic [FRAME_W-1:0] shift_q;
	logic out_q;
	logic oe_q;
	sari_pkg::sari_th_t th_q;
	sari_pkg::sari_mode_t mode_q;
	sari_pkg::sari_mode_t mode_entry_q;

	// Edges are only counted inside a frame; a select fall in the same cycle
	// as a clock edge wins so the new frame always starts at zero.
	wire count_fall = active_q & sclk_fall & ~cs_fall & ~cs_rise;
	wire count_rise = active_q & sclk_rise & ~cs_fall & ~cs_rise;
	wire [`SARI_CNT_W-1:0] fall_next = (fall_cnt_q == `SARI_CNT_MAX) ? fall_cnt_q : fall_cnt_q + 5'h01;
	wire [`SARI_CNT_W-1:0] rise_next = (rise_cnt_q == `SARI_CNT_MAX) ? rise_cnt_q : rise_cnt_q + 5'h01;
	wire last_fall = count_fall & (fall_next == `SARI_FALL_LAST);
	wire track_rise = count_rise & (rise_next == `SARI_RISE_TRACK);

	// Mode decision taken when select rises inside a frame.
	wire rise_noise = fall_cnt_q < `SARI_FALL_NOISE;
	wire rise_shutdown = ~rise_noise & (fall_cnt_q < `SARI_FALL_MODE);

	// The result is straight binary, so the held sample is framed without recoding.
	wire [FRAME_W-1:0] frame_load = {{(`SARI_LEAD_ZEROS + 1){1'b0}}, sample_in, {`SARI_TRAIL_ZEROS{1'b0}}};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fall_cnt_q <= '0;
			rise_cnt_q <= '0;
		end else if (clk_en) begin
			if (cs_fall) begin
				fall_cnt_q <= '0;
				rise_cnt_q <= '0;
			end else begin
				if (count_fall) begin
					fall_cnt_q <= fall_next;
				end
				if (count_rise) begin
					rise_cnt_q <= rise_next;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			active_q <= 1'b0;
		end else if (clk_en) begin
			if (cs_fall) begin
				active_q <= 1'b1;
			end else if (cs_rise) begin
				active_q <= 1'b0;
			end
		end
	end

	// Track/hold: the sample is frozen at select falling and released at the
	// thirteenth rise, which also opens the acquisition window for the next one.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			th_q <= sari_pkg::SARI_TRACK;
		end else if (clk_en) begin
			if (cs_fall) begin
				th_q <= sari_pkg::SARI_HOLD;
			end else if (track_rise || cs_rise) begin
				th_q <= sari_pkg::SARI_TRACK;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shift_q <= '0;
		end else if (clk_en) begin
			if (cs_fall) begin
				shift_q <= frame_load;
			end else if (count_fall) begin
				shift_q <= {shift_q[FRAME_W-2:0], 1'b0};
			end
		end
	end

	// The extra zero is on the line as soon as select falls; each falling
	// clock edge then presents the next bit for the host's rising edge.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			out_q <= 1'b0;
		end else if (clk_en) begin
			if (cs_fall) begin
				out_q <= frame_load[FRAME_W-1];
			end else if (count_fall) begin
				out_q <= shift_q[FRAME_W-2];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			oe_q <= 1'b0;
		end else if (clk_en) begin
			if (cs_fall) begin
				oe_q <= 1'b1;
			end else if (cs_rise || last_fall) begin
				oe_q <= 1'b0;
			end
		end
	end

	// Power mode. A rise before the second fall is treated as noise; a rise
	// after the tenth fall only truncates the word and keeps the part awake.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_q <= sari_pkg::SARI_NORMAL;
			mode_entry_q <= sari_pkg::SARI_NORMAL;
		end else if (clk_en) begin
			if (cs_fall) begin
				mode_entry_q <= mode_q;
				mode_q <= sari_pkg::SARI_NORMAL;
			end else if (cs_rise && active_q && rise_shutdown) begin
				mode_q <= sari_pkg::SARI_SHUTDOWN;
			end else if (cs_rise && active_q && rise_noise) begin
				mode_q <= mode_entry_q;
			end
		end
	end

	// The mode held before the frame is kept so that a glitch on select
	// cannot wake a sleeping part or put a running one to sleep.

	assign link.serial_result_out = out_q;
	assign link.serial_result_oe = oe_q;
	assign in_hold = (th_q == sari_pkg::SARI_HOLD);
	assign in_shutdown = (mode_q == sari_pkg::SARI_SHUTDOWN);
	assign frame_active = active_q;
endmodule
`default_nettype wire

// *** hw/sari_defs.svh ***
// Constants shared by both ends of the serial converter readout link.
`ifndef SARI_DEFS_SVH
`define SARI_DEFS_SVH

`define SARI_RESULT_BITS 10
`define SARI_FRAME_BITS 16
`define SARI_LEAD_ZEROS 3
`define SARI_TRAIL_ZEROS 2
`define SARI_CNT_W 5
`define SARI_CNT_MAX 5'h1f
`define SARI_FALL_NOISE 5'h02
`define SARI_FALL_MODE 5'h0a
`define SARI_RISE_TRACK 5'h0d
`define SARI_FALL_LAST 5'h10
`define SARI_HOST_CYCLES 5'h10
`define SARI_HOST_SLEEP_FALLS 5'h05
`define SARI_THROUGHPUT_CYCLES 20
`define SARI_CLK_PERIOD_NS 100
`define SARI_ACQ_NS 350
`define SARI_ACQ_CYC ((`SARI_ACQ_NS + `SARI_CLK_PERIOD_NS - 1) / `SARI_CLK_PERIOD_NS)
`define SARI_SCLK_HALF_CYC 10

`endif

// *** hw/sari_pkg.sv ***
// Types shared by both ends of the serial converter readout link.
`default_nettype none
package sari_pkg;
	typedef enum logic [0:0] {
		SARI_TRACK = 1'b0,
		SARI_HOLD = 1'b1
	} sari_th_t;
	typedef enum logic [0:0] {
		SARI_NORMAL = 1'b0,
		SARI_SHUTDOWN = 1'b1
	} sari_mode_t;
	typedef enum logic [2:0] {
		SARI_H_IDLE = 3'b000,
		SARI_H_SETUP = 3'b001,
		SARI_H_LOW = 3'b010,
		SARI_H_HIGH = 3'b011,
		SARI_H_GAP = 3'b100
	} sari_hstate_t;
endpackage
`default_nettype wire

// *** hw/sari_link_if.sv ***
// Three-wire link between the converter and its host controller.
`default_nettype none
interface sari_link_if;
	logic cs_n;
	logic sclk;
	logic serial_result_out;
	logic serial_result_oe;
	wire serial_result_line;
	// A weak pull-down is modelled so that a floating data line reads low.
	assign serial_result_line = serial_result_oe ? serial_result_out : 1'b0;
	modport device (
		input cs_n,
		input sclk,
		output serial_result_out,
		output serial_result_oe
	);
	modport host (
		output cs_n,
		output sclk,
		input serial_result_line
	);
endinterface
`default_nettype wire

// *** hw/sari_host.sv ***
// Host end: generates select and serial clock, collects each result word.
`include "sari_defs.svh"
`default_nettype none
module sari_host #(
	parameter int unsigned RESULT_BITS = `SARI_RESULT_BITS,
	parameter int unsigned SCLK_HALF_CYC = `SARI_SCLK_HALF_CYC,
	parameter int unsigned FRAME_CYCLES = `SARI_THROUGHPUT_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	sari_link_if.host link,
	input wire logic start,
	input wire logic sleep,
	output logic busy,
	output logic [RESULT_BITS-1:0] result,
	output logic result_valid,
	output logic result_usable
);
	localparam int FRAME_W = `SARI_LEAD_ZEROS + 1 + RESULT_BITS + `SARI_TRAIL_ZEROS;
	localparam int PAD_CYC = (FRAME_CYCLES - `SARI_FRAME_BITS) * 2 * SCLK_HALF_CYC;
	localparam int GAP_CYC = (PAD_CYC > `SARI_ACQ_CYC) ? PAD_CYC : `SARI_ACQ_CYC;
	localparam logic [15:0] HALF_END = 16'(SCLK_HALF_CYC - 1);
	localparam logic [15:0] GAP_END = 16'(GAP_CYC - 1);

	sari_pkg::sari_hstate_t st_q;
	logic [15:0] tmr_q;
	logic [`SARI_CNT_W-1:0] cyc_q;
	logic cs_n_q;
	logic sclk_q;
	logic sleep_frame_q;
	logic dummy_q;
	logic [FRAME_W-1:0] cap_q;
	logic [RESULT_BITS-1:0] result_q;
	logic valid_q;
	logic usable_q;
	logic [2:0] line_sync_q;
	logic line_lvl_q;

	// The data line is driven from the converter's side and is synchronised.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			line_sync_q <= 3'h0;
			line_lvl_q <= 1'b0;
		end else if (clk_en) begin
			line_sync_q <= {line_sync_q[1:0], link.serial_result_line};
			if (line_sync_q[1] == line_sync_q[2]) begin
				line_lvl_q <= line_sync_q[2];
			end
		end
	end

	wire half_done = (tmr_q == HALF_END);
	wire gap_done = (tmr_q == GAP_END);
	wire frame_end = sleep_frame_q ? (cyc_q == `SARI_HOST_SLEEP_FALLS) : (cyc_q == `SARI_HOST_CYCLES);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= sari_pkg::SARI_H_IDLE;
			tmr_q <= '0;
			cyc_q <= '0;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b1;
			sleep_frame_q <= 1'b0;
			cap_q <= '0;
			valid_q <= 1'b0;
		end else if (clk_en) begin
			valid_q <= 1'b0;
			unique case (st_q)
				sari_pkg::SARI_H_IDLE: begin
					if (start) begin
						cs_n_q <= 1'b0;
						sleep_frame_q <= sleep;
						cyc_q <= '0;
						tmr_q <= '0;
						st_q <= sari_pkg::SARI_H_SETUP;
					end
				end
				sari_pkg::SARI_H_SETUP: begin
					// Clock idles high so select falls ahead of the first falling edge.
					tmr_q <= tmr_q + 16'h0001;
					if (half_done) begin
						tmr_q <= '0;
						sclk_q <= 1'b0;
						cyc_q <= cyc_q + 5'h01;
						st_q <= sari_pkg::SARI_H_LOW;
					end
				end
				sari_pkg::SARI_H_LOW: begin
					tmr_q <= tmr_q + 16'h0001;
					if (half_done) begin
						tmr_q <= '0;
						sclk_q <= 1'b1;
						cap_q <= {cap_q[FRAME_W-2:0], line_lvl_q};
						st_q <= sari_pkg::SARI_H_HIGH;
					end
				end
				sari_pkg::SARI_H_HIGH: begin
					tmr_q <= tmr_q + 16'h0001;
					if (half_done && frame_end) begin
						tmr_q <= '0;
						cs_n_q <= 1'b1;
						valid_q <= ~sleep_frame_q;
						st_q <= sari_pkg::SARI_H_GAP;
					end else if (half_done) begin
						tmr_q <= '0;
						sclk_q <= 1'b0;
						cyc_q <= cyc_q + 5'h01;
						st_q <= sari_pkg::SARI_H_LOW;
					end
				end
				sari_pkg::SARI_H_GAP: begin
					// Quiet time and acquisition window before the next frame.
					tmr_q <= tmr_q + 16'h0001;
					if (gap_done) begin
						tmr_q <= '0;
						st_q <= sari_pkg::SARI_H_IDLE;
					end
				end
				default: begin
					st_q <= sari_pkg::SARI_H_IDLE;
				end
			endcase
		end
	end

	// The converter may wake in either mode, so the first result after reset
	// or after a shutdown frame is marked unusable.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dummy_q <= 1'b1;
			result_q <= '0;
			usable_q <= 1'b0;
		end else if (clk_en) begin
			if (valid_q) begin
				result_q <= cap_q[FRAME_W-1-`SARI_LEAD_ZEROS:`SARI_TRAIL_ZEROS+1];
				usable_q <= ~dummy_q;
				dummy_q <= 1'b0;
			end else if (st_q == sari_pkg::SARI_H_GAP && sleep_frame_q) begin
				dummy_q <= 1'b1;
			end
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.sclk = sclk_q;
	assign busy = (st_q != sari_pkg::SARI_H_IDLE);
	assign result = result_q;
	assign result_valid = valid_q;
	assign result_usable = usable_q;
endmodule
`default_nettype wire

// *** testbench/sari_link_props.sv ***
// Concurrent checks on the link between the host end and the converter end.
`default_nettype none
module sari_link_props (
	input wire logic clk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_result_out,
	input wire logic serial_result_oe
);
	logic sclk_q;
	logic cs_q;
	logic [4:0] fall_q;
	logic [4:0] rise_q;
	logic [9:0] gap_q;
	wire logic fell_s = sclk_q && !sclk;
	wire logic rose_s = !sclk_q && sclk;
	wire logic cs_fell = cs_q && !cs_n;
	wire logic [4:0] fall_d = cs_fell ? 5'h00 : (fell_s && !cs_n && fall_q != 5'h1f) ? fall_q + 5'h01 : fall_q;
	wire logic [4:0] rise_d = cs_fell ? 5'h00 : (rose_s && !cs_n && rise_q != 5'h1f) ? rise_q + 5'h01 : rise_q;
	// The track interval starts at the thirteenth rise; saturating keeps idle periods harmless.
	wire logic [9:0] gap_d = (rose_s && !cs_n && rise_q == 5'h0c) ? 10'h000 : (gap_q != 10'h3ff) ? gap_q + 10'h001 : gap_q;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sclk_q <= 1'b1;
			cs_q <= 1'b1;
			fall_q <= 5'h00;
			rise_q <= 5'h00;
			gap_q <= 10'h3ff;
		end else begin
			sclk_q <= sclk;
			cs_q <= cs_n;
			fall_q <= fall_d;
			rise_q <= rise_d;
			gap_q <= gap_d;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	AST_OE_ON: assert property ($fell(cs_n) |-> ##[2:6] serial_result_oe)
		else $error("data line not driven after select fall");
	AST_OE_IN_FRAME: assert property (rose_s && !cs_n && fall_q != 5'h00 && fall_q < 5'h10 |-> serial_result_oe)
		else $error("data line floats inside frame");
	AST_OE_OFF_CS: assert property ($rose(cs_n) |-> ##[1:6] !serial_result_oe)
		else $error("data line still driven after select rise");
	AST_IDLE_QUIET: assert property (cs_n [*8] |-> !serial_result_oe)
		else $error("data line driven while deselected");
	AST_OE_OFF_16: assert property ($rose(fall_q == 5'h10) |-> ##[1:6] !serial_result_oe)
		else $error("data line still driven after last fall");
	AST_LEAD_ZERO: assert property (rose_s && !cs_n && fall_q inside {5'h01, 5'h02, 5'h03} |-> !serial_result_out)
		else $error("leading bit not zero");
	AST_TRAIL_ZERO: assert property (rose_s && !cs_n && fall_q inside {5'h0e, 5'h0f} |-> !serial_result_out)
		else $error("trailing bit not zero");
	AST_STABLE_HIGH: assert property (rose_s && !cs_n |=> ($stable(serial_result_out) || cs_n) [*6])
		else $error("data bit changed while clock high");
	AST_CYCLES: assert property ($rose(cs_n) |-> fall_q == 5'h10 || fall_q == 5'h05)
		else $error("wrong clock count in frame");
	AST_ACQ: assert property ($fell(cs_n) |-> gap_q >= 10'h003)
		else $error("select fell too soon after track start");
	AST_PAD: assert property ($fell(cs_n) |-> sclk)
		else $error("select fell with clock low");
	cover property ($rose(cs_n) && fall_q == 5'h10);
	cover property ($rose(cs_n) && fall_q == 5'h05);
	cover property (cs_fell && gap_q != 10'h3ff);
endmodule
`default_nettype wire

// *** testbench/serial_adc_readout_interface_tb.sv ***
// Bench joining host and converter, plus a second converter driven directly by the bench.
`default_nettype none
module serial_adc_readout_interface_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	logic sleep = 1'b0;
	logic [9:0] sample_in = 10'h000;
	logic busy, result_valid, result_usable, in_hold, in_shutdown, frame_active;
	logic in_hold2, in_shutdown2, frame_active2;
	logic [9:0] result;
	int err_count = 0;
	int comparisons = 0;
	int falls_tab[7] = '{9, 1, 10, 2, 12, 16, 1};
	logic sd_tab[7] = '{1, 1, 0, 1, 0, 0, 0};
	sari_link_if link ();
	sari_link_if link2 ();
	sari_device sari_device_inst (.clk(clk), .reset(reset), .clk_en(1'b1), .link(link), .sample_in(sample_in),
		.in_hold(in_hold), .in_shutdown(in_shutdown), .frame_active(frame_active));
	sari_device sari_device_inst2 (.clk(clk), .reset(reset), .clk_en(1'b1), .link(link2), .sample_in(sample_in),
		.in_hold(in_hold2), .in_shutdown(in_shutdown2), .frame_active(frame_active2));
	sari_host sari_host_inst (.clk(clk), .reset(reset), .clk_en(1'b1), .link(link), .start(start), .sleep(sleep),
		.busy(busy), .result(result), .result_valid(result_valid), .result_usable(result_usable));
	sari_link_props sari_link_props_inst (.clk(clk), .reset(reset), .cs_n(link.cs_n), .sclk(link.sclk),
		.serial_result_out(link.serial_result_out), .serial_result_oe(link.serial_result_oe));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t ns: %s", $time, msg);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d, comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic bail(input logic hung);
		if (hung) begin
			err_count++;
			conclude();
		end
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 1000 && busy !== 1'b0; i++) begin
			tick(1);
		end
		bail(i == 1000);
	endtask
	task automatic host_frame(input logic [9:0] value, input logic exp_usable);
		int i;
		int held;
		logic got;
		held = 0;
		got = 1'b0;
		wait_idle();
		sample_in = value;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		for (i = 0; i < 1000 && !got; i++) begin
			tick(1);
			held += in_hold;
			got = result_valid;
		end
		bail(!got);
		check(in_hold, 16'h0000, "hold after frame");
		check(held >= 256 && held <= 264, 16'h0001, "hold length");
		tick(1);
		check(result, value, "result word");
		check(result_usable, exp_usable, "usable flag");
		check(in_shutdown, 16'h0000, "mode after full frame");
	endtask
	task automatic host_sleep();
		int i;
		logic seen;
		seen = 1'b0;
		wait_idle();
		sleep = 1'b1;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		sleep = 1'b0;
		for (i = 0; i < 300; i++) begin
			tick(1);
			seen |= result_valid;
		end
		check(seen, 16'h0000, "result from sleep frame");
		check(in_shutdown, 16'h0001, "shutdown after early rise");
		tick(200);
		check(in_shutdown, 16'h0001, "shutdown kept while idle");
	endtask
	// The bench makes this clock at 800 ns and samples each bit late in the high half.
	task automatic drive_frame(input int falls, input logic exp_sd);
		int k;
		logic [15:0] word;
		link2.cs_n = 1'b0;
		tick(4);
		for (k = 0; k < falls; k++) begin
			link2.sclk = 1'b0;
			tick(4);
			link2.sclk = 1'b1;
			tick(3);
			word = {word[14:0], link2.serial_result_line};
			tick(1);
		end
		tick(4);
		check(link2.serial_result_oe, falls < 16, "line release");
		check(in_hold2, falls < 13, "hold state");
		check(in_shutdown2, 16'h0000, "normal while selected");
		link2.cs_n = 1'b1;
		tick(8);
		check(link2.serial_result_oe, 16'h0000, "release at select rise");
		check(frame_active2, 16'h0000, "frame end");
		check(in_shutdown2, exp_sd, "mode after select rise");
		if (falls == 16) begin
			check(word, {3'h0, sample_in, 3'h0}, "frame bits");
		end
		tick(12);
	endtask
	initial begin
		link2.cs_n = 1'b1;
		link2.sclk = 1'b1;
		tick(10);
		reset = 1'b0;
		host_frame(10'h000, 1'b0);
		host_frame(10'h3ff, 1'b1);
		host_frame(10'h2aa, 1'b1);
		host_sleep();
		host_frame(10'h155, 1'b0);
		host_frame(10'h001, 1'b1);
		sample_in = 10'h2c5;
		for (int i = 0; i < 7; i++) begin
			drive_frame(falls_tab[i], sd_tab[i]);
		end
		conclude();
	end
endmodule
`default_nettype wire
